// >>> common/plt_pkg.sv
// Package of constants and types for the palette lookup host port
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
package plt_pkg;
  localparam int         PLT_ENTRIES  = 256;
  localparam int         PLT_ALT      = 8;
  localparam logic [15:0] ADDR_MASK   = 16'h03c6;
  localparam logic [15:0] ADDR_RDIDX  = 16'h03c7;
  localparam logic [15:0] ADDR_WRIDX  = 16'h03c8;
  localparam logic [15:0] ADDR_DATA   = 16'h03c9;
  localparam logic [7:0]  MASK_RST    = 8'hff;
  localparam logic [7:0]  INDEX_RST   = 8'h00;
  localparam logic [1:0]  STATE_WR    = 2'b00;
  localparam logic [1:0]  STATE_RD    = 2'b10;
  localparam int          STATE_LSB   = 0;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } plt_rgb_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } plt_io_req_t;

  typedef enum logic [1:0] {PLT_BPP8, PLT_BPP15, PLT_BPP16, PLT_BPP24} plt_depth_t;
  typedef enum logic [1:0] {PLT_RED, PLT_GREEN, PLT_BLUE} plt_comp_t;
endpackage

// >>> design/plt_color_store.sv
// Color entry storage: standard set plus alternate cursor set
`timescale 1ns/1ps
module plt_color_store #(
  parameter int ENTRIES = plt_pkg::PLT_ENTRIES,
  parameter int ALT     = plt_pkg::PLT_ALT
) (
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic              wr_alt,
  input  wire logic [7:0]        wr_idx,
  input  wire plt_pkg::plt_rgb_t wr_color,
  input  wire logic              rd_alt,
  input  wire logic [7:0]        rd_idx,
  output plt_pkg::plt_rgb_t      rd_color,
  input  wire logic [7:0]        px_idx,
  output plt_pkg::plt_rgb_t      px_color
);
  import plt_pkg::*;
  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // No reset: colors are data, software loads them before use
  plt_rgb_t std_q [ENTRIES];
  plt_rgb_t alt_q [ALT];

  always_ff @(posedge clock)
  begin
    if (wr_en && !wr_alt)
      std_q[wr_idx] <= wr_color;
    if (wr_en && wr_alt)
      alt_q[wr_idx[$clog2(ALT)-1:0]] <= wr_color;
  end

  always_comb
  begin
    rd_color = rd_alt ? alt_q[rd_idx[$clog2(ALT)-1:0]] : std_q[rd_idx];
    px_color = std_q[px_idx];
  end
endmodule // plt_color_store

// >>> design/plt_host_port.sv
// Palette lookup table with byte-wide host ports and pixel path
`timescale 1ns/1ps
module plt_host_port (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire plt_pkg::plt_io_req_t io_req,
  output logic [7:0]                io_rdata_q,
  output logic                      io_rvalid_q,
  input  wire logic                 alt_select,
  input  wire logic                 pix_valid,
  input  wire plt_pkg::plt_depth_t  pix_depth,
  input  wire logic [23:0]          pix_data,
  output plt_pkg::plt_rgb_t         pix_rgb_q,
  output logic                      pix_valid_q
);
  import plt_pkg::*;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input plt_io_req_t q, input logic [15:0] a);
    hit = (q.addr == a);
  endfunction

  function automatic logic [7:0] widen(input logic [7:0] v, input int bits);
    widen = (bits == 5) ? {v[4:0], v[4:2]} : {v[5:0], v[5:4]};
  endfunction

  logic wr_mask, wr_ridx, wr_widx, wr_data, rd_data, rd_any;
  always_comb
  begin
    wr_mask = io_req.wr && hit(io_req, ADDR_MASK);
    wr_ridx = io_req.wr && hit(io_req, ADDR_RDIDX);
    wr_widx = io_req.wr && hit(io_req, ADDR_WRIDX);
    wr_data = io_req.wr && hit(io_req, ADDR_DATA);
    // A write in the same cycle shadows a read
    rd_any  = io_req.rd && !io_req.wr;
    rd_data = rd_any && hit(io_req, ADDR_DATA);
  end

  // --------------------------------------------------------------------------
  // Host registers
  // --------------------------------------------------------------------------
  logic [7:0] mask_q, mask_d, ridx_q, ridx_d, widx_q, widx_d;
  logic [7:0] red_q, red_d, green_q, green_d, rdata_d;
  logic       last_rd_q, last_rd_d, commit;
  plt_comp_t  comp_q, comp_d;
  plt_rgb_t   rd_color, px_color;

  always_comb
  begin
    mask_d    = mask_q;
    ridx_d    = ridx_q;
    widx_d    = widx_q;
    red_d     = red_q;
    green_d   = green_q;
    last_rd_d = last_rd_q;
    comp_d    = comp_q;
    commit    = 1'b0;
    rdata_d   = 8'h00;
    if (wr_mask)
      mask_d = io_req.wdata;
    if (wr_ridx)
    begin
      ridx_d    = io_req.wdata;
      last_rd_d = 1'b1;
      comp_d    = PLT_RED;
    end
    if (wr_widx)
    begin
      widx_d    = io_req.wdata;
      last_rd_d = 1'b0;
      comp_d    = PLT_RED;
    end
    if (wr_data)
    begin
      unique case (comp_q)
        PLT_RED:   begin red_d = io_req.wdata;   comp_d = PLT_GREEN; end
        PLT_GREEN: begin green_d = io_req.wdata; comp_d = PLT_BLUE;  end
        PLT_BLUE:
        begin
          commit = 1'b1;
          comp_d = PLT_RED;
          widx_d = widx_q + 8'h01;
        end
        default:   comp_d = PLT_RED;
      endcase
    end
    if (rd_data)
    begin
      unique case (comp_q)
        PLT_RED:   begin rdata_d = rd_color.r; comp_d = PLT_GREEN; end
        PLT_GREEN: begin rdata_d = rd_color.g; comp_d = PLT_BLUE;  end
        PLT_BLUE:
        begin
          rdata_d = rd_color.b;
          comp_d  = PLT_RED;
          ridx_d  = ridx_q + 8'h01;
        end
        default:   comp_d = PLT_RED;
      endcase
    end
    else if (rd_any && hit(io_req, ADDR_MASK))
      rdata_d = mask_q;
    else if (rd_any && hit(io_req, ADDR_RDIDX))
      rdata_d = {6'h00, (last_rd_q ? STATE_RD : STATE_WR)};
    else if (rd_any && hit(io_req, ADDR_WRIDX))
      rdata_d = widx_q;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q      <= MASK_RST;
      ridx_q      <= INDEX_RST;
      widx_q      <= INDEX_RST;
      red_q       <= 8'h00;
      green_q     <= 8'h00;
      last_rd_q   <= 1'b0;
      comp_q      <= PLT_RED;
      io_rdata_q  <= 8'h00;
      io_rvalid_q <= 1'b0;
    end
    else
    begin
      mask_q      <= mask_d;
      ridx_q      <= ridx_d;
      widx_q      <= widx_d;
      red_q       <= red_d;
      green_q     <= green_d;
      last_rd_q   <= last_rd_d;
      comp_q      <= comp_d;
      io_rdata_q  <= rdata_d;
      io_rvalid_q <= rd_any;
    end
  end

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Indexed pixel lookup (PLT_BPP8) always uses the standard set; cursor colors are read elsewhere
  plt_color_store #(
    .ENTRIES (PLT_ENTRIES),
    .ALT     (PLT_ALT)
  ) u_store (
    .clock    (clock),
    .wr_en    (commit),
    .wr_alt   (alt_select),
    .wr_idx   (widx_q),
    .wr_color ({red_q, green_q, io_req.wdata}),
    .rd_alt   (alt_select),
    .rd_idx   (ridx_q),
    .rd_color (rd_color),
    .px_idx   (pix_data[7:0] & mask_q),
    .px_color (px_color)
  );

  // --------------------------------------------------------------------------
  // Pixel path
  // --------------------------------------------------------------------------
  plt_rgb_t rgb_d;
  always_comb
  begin
    unique case (pix_depth)
      PLT_BPP8:  rgb_d = px_color;
      PLT_BPP15: rgb_d = {widen({3'h0, pix_data[14:10]}, 5), widen({3'h0, pix_data[9:5]}, 5),
                          widen({3'h0, pix_data[4:0]}, 5)};
      PLT_BPP16: rgb_d = {widen({3'h0, pix_data[15:11]}, 5), widen({2'h0, pix_data[10:5]}, 6),
                          widen({3'h0, pix_data[4:0]}, 5)};
      PLT_BPP24: rgb_d = pix_data;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pix_rgb_q   <= '0;
      pix_valid_q <= 1'b0;
    end
    else
    begin
      pix_rgb_q   <= pix_valid ? rgb_d : pix_rgb_q;
      pix_valid_q <= pix_valid;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Hosts may strobe back to back or leave an idle cycle; both spacings are watched
  AST_READ_ORDER: assert property (rd_data && comp_q == PLT_RED ##1 rd_data
    |-> ##1 io_rdata_q == $past(rd_color.g)) else $error("green not second");
  AST_READ_GAP: assert property (rd_data && comp_q == PLT_RED
    ##1 !(wr_ridx || wr_widx || wr_data || rd_data) ##1 rd_data
    |-> ##1 io_rdata_q == $past(rd_color.g)) else $error("green not second after gap");
  AST_READ_INC: assert property (rd_data && comp_q == PLT_BLUE && !wr_ridx
    |=> ridx_q == $past(ridx_q) + 8'h01) else $error("read index not stepped");
  AST_WRITE_HOLD: assert property (commit |-> comp_q == PLT_BLUE && wr_data)
    else $error("entry updated early");
  AST_WRITE_INC: assert property (commit |=> widx_q == $past(widx_q) + 8'h01)
    else $error("write index not stepped");
  AST_WRAP: assert property (commit && widx_q == 8'hff |=> widx_q == 8'h00)
    else $error("write index did not wrap");
  AST_STATE: assert property (wr_ridx ##1 !wr_widx ##1 rd_any && hit(io_req, ADDR_RDIDX)
    |=> io_rdata_q == 8'h02) else $error("state not 10");
  AST_SEQ_RESET: assert property (wr_widx || wr_ridx |=> comp_q == PLT_RED)
    else $error("sequencer not reset");
  AST_MASK_RW: assert property (wr_mask ##1 !wr_mask ##1 rd_any && hit(io_req, ADDR_MASK)
    |=> io_rdata_q == $past(io_req.wdata, 3)) else $error("mask readback");
  AST_INDEXED: assert property (pix_valid && pix_depth == PLT_BPP8
    |=> pix_rgb_q == $past(px_color)) else $error("lookup mismatch");
  AST_DIRECT: assert property (pix_valid && pix_depth == PLT_BPP24
    |=> pix_rgb_q == $past(pix_data)) else $error("direct mismatch");

  COV_ENTRY_WRITE: cover property (wr_widx ##[1:4] wr_data ##[1:4] wr_data ##[1:4] commit);
  COV_ENTRY_READ: cover property (wr_ridx ##[1:4] rd_data ##[1:4] rd_data ##[1:4] rd_data);
  COV_DIRECT16: cover property (pix_valid && pix_depth == PLT_BPP16);
endmodule // plt_host_port

// >>> sim/plt_host_model.sv
// Host processor model issuing byte-wide I/O cycles
`timescale 1ns/1ps
module plt_host_model (
  input  wire logic            clock,
  output plt_pkg::plt_io_req_t io_req,
  input  wire logic [7:0]      io_rdata_q,
  input  wire logic            io_rvalid_q
);
  import plt_pkg::*;
  initial io_req = '0;
  // Strobe drops a full edge before the next access, never in the same step
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic v);
    @(posedge clock);
    #10;
    io_req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    #10;
    q = io_rdata_q;
    v = io_rvalid_q;
    io_req.rd = 1'b0;
    io_req.wr = 1'b0;
    // Released data lines flip so a stale byte never looks live
    io_req.wdata = ~d;
  endtask
endmodule // plt_host_model

// >>> sim/tb_palette_lookup_host_port.sv
// Self-checking bench for the palette lookup host port
`timescale 1ns/1ps
module tb_palette_lookup_host_port;
  import plt_pkg::*;
  logic        clock, reset_n, alt_select, pix_valid, io_rvalid_q, pix_valid_q;
  plt_io_req_t io_req;
  logic [7:0]  io_rdata_q;
  plt_depth_t  pix_depth;
  logic [23:0] pix_data, hold, last;
  plt_rgb_t    pix_rgb_q;
  logic [23:0] std_tab [256];
  logic [23:0] alt_tab [8];
  logic [7:0]  mask = MASK_RST, ridx = INDEX_RST, widx = INDEX_RST;
  logic [1:0]  st = STATE_WR;
  int          seq = 0;
  int          miscompares = 0;
  int          check_count = 0;

  plt_host_port i_plt_host_port (.clock(clock), .reset_n(reset_n), .io_req(io_req),
    .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q), .alt_select(alt_select),
    .pix_valid(pix_valid), .pix_depth(pix_depth), .pix_data(pix_data),
    .pix_rgb_q(pix_rgb_q), .pix_valid_q(pix_valid_q));
  plt_host_model i_plt_host_model (.clock(clock), .io_req(io_req),
    .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q));

  // --------------------------------------------------------------------
  // Reference model and checks
  // --------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    i_plt_host_model.acc(1'b1, a, d, q, v);
    chk(24'(v), 24'(1'b0));
    chk(24'(q), 24'h00_0000);
    if (a == ADDR_MASK) mask = d;
    if (a == ADDR_RDIDX) ridx = d;
    if (a == ADDR_WRIDX) widx = d;
    if (a == ADDR_RDIDX || a == ADDR_WRIDX) seq = 0;
    if (a == ADDR_RDIDX) st = STATE_RD;
    if (a == ADDR_WRIDX) st = STATE_WR;
    if (a == ADDR_DATA)
    begin
      hold = {hold[15:0], d};
      if (seq == 2 && alt_select) alt_tab[widx[2:0]] = hold;
      if (seq == 2 && !alt_select) std_tab[widx] = hold;
      if (seq == 2) widx++;
      seq = (seq + 1) % 3;
    end
  endtask

  task automatic io_r(input logic [15:0] a);
    logic [7:0]  q, e;
    logic        v;
    logic [23:0] ent;
    i_plt_host_model.acc(1'b0, a, 8'h00, q, v);
    ent = alt_select ? alt_tab[ridx[2:0]] : std_tab[ridx];
    e = 8'h00;
    if (a == ADDR_MASK) e = mask;
    if (a == ADDR_RDIDX) e = {6'h00, st};
    if (a == ADDR_WRIDX) e = widx;
    if (a == ADDR_DATA)
    begin
      e = ent[8*(2-seq) +: 8];
      if (seq == 2) ridx++;
      seq = (seq + 1) % 3;
    end
    chk(24'(v), 24'(1'b1));
    chk(24'(q), 24'(e));
  endtask

  function automatic logic [23:0] px_exp(plt_depth_t dp, logic [23:0] d);
    case (dp)
      PLT_BPP15: return {d[14:10], d[14:12], d[9:5], d[9:7], d[4:0], d[4:2]};
      PLT_BPP16: return {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
      PLT_BPP24: return d;
      default:   return std_tab[d[7:0] & mask];
    endcase
  endfunction

  task automatic pix_run(input int n);
    repeat (n)
    begin
      pix_valid = 1'($urandom);
      pix_depth = plt_depth_t'($urandom % 4);
      pix_data = 24'($urandom);
      @(posedge clock);
      #10;
      if (pix_valid) last = px_exp(pix_depth, pix_data);
      chk(24'(pix_valid_q), 24'(pix_valid));
      chk(pix_rgb_q, last);
    end
    pix_valid = 1'b0;
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and scenarios
  // --------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    #5_000_000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(17));
    {reset_n, alt_select, pix_valid, pix_data, last} = '0;
    pix_depth = PLT_BPP8;
    repeat (4) @(posedge clock);
    #10;
    reset_n = 1'b1;
    io_r(ADDR_MASK);
    io_r(ADDR_RDIDX);
    io_r(ADDR_WRIDX);
    io_r(16'h03c5);
    $display("test reset done");
    // Whole table in one pass; the write index must come back to zero
    for (int i = 0; i < 768; i++) io_w(ADDR_DATA, 8'($urandom));
    io_r(ADDR_WRIDX);
    io_w(ADDR_RDIDX, 8'hfe);
    io_r(ADDR_RDIDX);
    for (int i = 0; i < 768; i++) io_r(ADDR_DATA);
    $display("test table done");
    io_w(ADDR_WRIDX, 8'h05);
    io_w(ADDR_DATA, 8'h5a);
    io_w(ADDR_DATA, 8'ha5);
    io_w(ADDR_WRIDX, 8'h09);
    for (int i = 0; i < 3; i++) io_w(ADDR_DATA, 8'($urandom));
    io_w(ADDR_RDIDX, 8'h05);
    io_r(ADDR_DATA);
    io_w(ADDR_RDIDX, 8'h05);
    for (int i = 0; i < 15; i++) io_r(ADDR_DATA);
    $display("test restart done");
    alt_select = 1'b1;
    io_w(ADDR_WRIDX, 8'h00);
    for (int i = 0; i < 24; i++) io_w(ADDR_DATA, 8'($urandom));
    io_w(ADDR_RDIDX, 8'h00);
    for (int i = 0; i < 24; i++) io_r(ADDR_DATA);
    alt_select = 1'b0;
    io_w(ADDR_RDIDX, 8'h00);
    for (int i = 0; i < 3; i++) io_r(ADDR_DATA);
    $display("test alternate done");
    io_w(ADDR_MASK, 8'($urandom));
    io_r(ADDR_MASK);
    pix_run(400);
    $display("test pixel done");
    wrap_up();
  end
endmodule // tb_palette_lookup_host_port
